/* core/ipc_ctrl.sv */
// interrupt priority control: flags, enables, priorities, trap status, pending latch
//
// How it works
// - each source flag is set by hardware and stays until software writes zero
// - each source has an enable; disabled sources never reach the cpu
// - each source has a 3-bit programmable priority, eight levels
// - source n: flag word n/16 bit n%16, priority word n/4 slot n%4, vector n+8
// - pending vector latched in bits 7-0, its level in bits 11-8, read-only
// - cpu level is high bit plus status bits 7-5; 7+ or high bit blocks users
// - software writes low level bits; high bit at core bit 3 is read-only
// - nesting block at trap control bit 15 stops software writes to the low level bits; core loads still change them
// - trap control one holds nesting block, trap flags, overflow trap enables 10-9-8
// - address fault sets trap control one bit 3
// - oscillator fault sets bit 1, stack fault sets bit 2
// - global enable at bit 15 resets set; clear masks all but traps
// - bits 2-0 of control two pick edge polarity; one is falling
// - dma address fault sets soft trap status bit 5
// - loop stack overflow sets soft trap status bit 4
// - software hard trap sets hard trap status bit 0 only while control two bit 13 is set
// - core bit 15 selects variable (one) or fixed (zero) exception latency
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "ipc_params.svh"

module ipc_ctrl (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    // register port
    input  wire logic [7:0]              addr_i,
    input  wire ipc_pkg::ipc_word_t      wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output ipc_pkg::ipc_word_t           rdata_o,
    // request sources
    input  wire logic [63:0]             src_req_i,
    input  wire logic [2:0]              ext_line_i,
    // trap events, one-cycle pulses; priority hold status level
    input  wire logic                    address_fault_i,
    input  wire logic                    stack_fault_i,
    input  wire logic                    oscillator_fault_i,
    input  wire logic                    math_fault_i,
    input  wire logic                    dma_controller_trap_i,
    input  wire logic                    shift_accum_fault_i,
    input  wire logic                    divide_zero_i,
    input  wire logic                    accum_a_overflow_i,
    input  wire logic                    accum_b_overflow_i,
    input  wire logic                    accum_a_catastrophic_i,
    input  wire logic                    accum_b_catastrophic_i,
    input  wire logic                    dma_address_fault_i,
    input  wire logic                    loop_stack_overflow_i,
    input  wire logic                    software_trap_request_i,
    input  wire logic                    priority_hold_active_i,
    // cpu side
    input  wire logic                    cpu_level_load_i,
    input  wire ipc_pkg::ipc_lvl_t       cpu_level_new_i,
    output logic                         irq_o,
    output ipc_pkg::ipc_vec_t            pending_vector_number_o,
    output ipc_pkg::ipc_lvl_t            pending_level_field_o,
    output ipc_pkg::ipc_lvl_t            cpu_priority_level_o,
    output logic                         variable_latency_o
);
    import ipc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [63:0]  flag_q;
    logic [63:0]  en_q;
    logic [191:0] pri_q;
    ipc_word_t    trap1_q;
    ipc_word_t    glob2_q;
    ipc_word_t    soft3_q;
    ipc_word_t    hard4_q;
    logic [2:0]   lvl_lo_q;
    logic         lvl_hi_q;
    logic         var_q;
    ipc_vec_t     vec_q;
    ipc_lvl_t     ilr_q;
    logic [2:0]   ext_edge;
    logic [63:0]  set_ev;
    logic [63:0]  elig;
    logic         arb_hit;
    logic [5:0]   arb_idx;
    ipc_pri_t     arb_pri;
    logic         trap_hit;
    ipc_trap_t    trap_code;
    ipc_word_t    rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // external line edges feed sources 0, 20 and 29
    for (genvar g = 0; g < 3; g++) begin : g_ext
        ipc_edge_det u_edge (
            .clk_i     (clk_i),
            .nrst_i    (nrst_i),
            .line_i    (ext_line_i[g]),
            .falling_i (glob2_q[g]),
            .edge_o    (ext_edge[g])
        );
    end

    always_comb begin
        set_ev     = src_req_i;
        set_ev[0]  = src_req_i[0] | ext_edge[0];
        set_ev[20] = src_req_i[20] | ext_edge[1];
        set_ev[29] = src_req_i[29] | ext_edge[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // request flags: hardware set wins over a software clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_q <= 64'h0;
        end else begin
            for (int w = 0; w < `IPC_NFLAGW; w++) begin
                if (wr_i && addr_i == `IPC_OFF_FLAG0 + 8'(w)) begin
                    flag_q[w*16 +: 16] <= wdata_i | set_ev[w*16 +: 16];
                end else begin
                    flag_q[w*16 +: 16] <= flag_q[w*16 +: 16] | set_ev[w*16 +: 16];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_q <= 64'h0;
        end else begin
            for (int w = 0; w < `IPC_NFLAGW; w++) begin
                if (wr_i && addr_i == `IPC_OFF_EN0 + 8'(w)) begin
                    en_q[w*16 +: 16] <= wdata_i;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pri_q <= 192'h0;
        end else begin
            for (int w = 0; w < `IPC_NPRIW; w++) begin
                if (wr_i && addr_i == `IPC_OFF_PRI0 + 8'(w)) begin
                    for (int s = 0; s < 4; s++) begin
                        pri_q[(w*4+s)*3 +: 3] <= wdata_i[s*4 +: 3];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trap and control registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trap1_q <= 16'h0000;
        end else begin
            logic [15:0] ev;
            ev = 16'h0000;
            ev[14] = accum_a_overflow_i;
            ev[13] = accum_b_overflow_i;
            ev[12] = accum_a_catastrophic_i;
            ev[11] = accum_b_catastrophic_i;
            ev[7]  = shift_accum_fault_i;
            ev[6]  = divide_zero_i;
            ev[5]  = dma_controller_trap_i;
            ev[4]  = math_fault_i;
            ev[`IPC_T1_ADDR] = address_fault_i;
            ev[`IPC_T1_STK]  = stack_fault_i;
            ev[`IPC_T1_OSC]  = oscillator_fault_i;
            if (wr_i && addr_i == `IPC_OFF_TRAP1) begin
                trap1_q <= (wdata_i & `IPC_T1_WMASK) | ev;
            end else begin
                trap1_q <= trap1_q | ev;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            glob2_q <= `IPC_G2_RESET;
        end else begin
            if (wr_i && addr_i == `IPC_OFF_GLOB2) begin
                glob2_q <= wdata_i & `IPC_G2_WMASK;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            soft3_q <= 16'h0000;
            hard4_q <= 16'h0000;
        end else begin
            logic [15:0] sev;
            logic [15:0] hev;
            sev = 16'h0000;
            hev = 16'h0000;
            sev[`IPC_S3_DAE]  = dma_address_fault_i;
            sev[`IPC_S3_LOOP] = loop_stack_overflow_i;
            hev[`IPC_H4_SOFT_HARD_TRAP_FLAG] = software_trap_request_i & glob2_q[13];
            if (wr_i && addr_i == `IPC_OFF_SOFT3) begin
                soft3_q <= (wdata_i & `IPC_S3_WMASK) | sev;
            end else begin
                soft3_q <= soft3_q | sev;
            end
            if (wr_i && addr_i == `IPC_OFF_HARD4) begin
                hard4_q <= (wdata_i & `IPC_H4_WMASK) | hev;
            end else begin
                hard4_q <= hard4_q | hev;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu level; the core loads a new level on exception entry and return
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_lo_q <= 3'h0;
            lvl_hi_q <= 1'b0;
        end else if (cpu_level_load_i) begin
            lvl_lo_q <= cpu_level_new_i[2:0];
            lvl_hi_q <= cpu_level_new_i[3];
        end else if (wr_i && addr_i == `IPC_OFF_STATUS && !trap1_q[`IPC_T1_NEST]) begin
            lvl_lo_q <= wdata_i[`IPC_SR_LVL_LO +: 3];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            var_q <= 1'b0;
        end else if (wr_i && addr_i == `IPC_OFF_CORE) begin
            var_q <= wdata_i[`IPC_CC_VAR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // selection
    always_comb begin
        for (int i = 0; i < `IPC_NSRC; i++) begin
            // users blocked at level 7+, by the high bit, or with global enable clear
            elig[i] = flag_q[i] & en_q[i] & glob2_q[`IPC_G2_GIE] & ~lvl_hi_q
                      & (pri_q[i*3 +: 3] > lvl_lo_q);
        end
    end

    ipc_arbiter u_arb (
        .elig_i (elig),
        .pri_i  (pri_q),
        .hit_o  (arb_hit),
        .idx_o  (arb_idx),
        .pri_o  (arb_pri)
    );

    // traps bypass the global enable; fixed order address first
    always_comb begin
        trap_hit  = 1'b1;
        trap_code = IPC_TRAP_ADDR;
        if (trap1_q[`IPC_T1_ADDR]) begin
            trap_code = IPC_TRAP_ADDR;
        end else if (hard4_q[`IPC_H4_SOFT_HARD_TRAP_FLAG]) begin
            trap_code = IPC_TRAP_HARD;
        end else if (trap1_q[`IPC_T1_STK]) begin
            trap_code = IPC_TRAP_STACK;
        end else if (trap1_q[4]) begin
            trap_code = IPC_TRAP_MATH;
        end else if (trap1_q[5]) begin
            trap_code = IPC_TRAP_DMA;
        end else if (soft3_q[`IPC_S3_DAE] | soft3_q[`IPC_S3_LOOP]) begin
            trap_code = IPC_TRAP_SOFT;
        end else begin
            trap_hit = 1'b0;
        end
    end

    // pending latch; trap level fixed at the top value
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vec_q <= 8'h00;
            ilr_q <= 4'h0;
        end else if (trap_hit) begin
            vec_q <= {5'h00, trap_code};
            ilr_q <= 4'hf;
        end else if (arb_hit) begin
            vec_q <= {2'h0, arb_idx} + `IPC_VEC_BASE;
            ilr_q <= {1'b0, arb_pri};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read, one cycle later
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 16'h0000;
        end else if (rd_i) begin
            rdata_q <= 16'h0000;
            case (addr_i)
                `IPC_OFF_STATUS:   rdata_q <= {8'h00, lvl_lo_q, 5'h00};
                `IPC_OFF_CORE:     rdata_q <= {var_q, 11'h000, lvl_hi_q, 3'h0};
                `IPC_OFF_TRAP1:    rdata_q <= trap1_q;
                `IPC_OFF_GLOB2:    rdata_q <= {glob2_q[15], priority_hold_active_i,
                                               glob2_q[13:0]};
                `IPC_OFF_SOFT3:    rdata_q <= soft3_q;
                `IPC_OFF_HARD4:    rdata_q <= hard4_q;
                `IPC_OFF_VECLATCH: rdata_q <= {4'h0, ilr_q, vec_q};
                default: begin
                    if (addr_i[7:2] == `IPC_OFF_FLAG0 >> 2) begin
                        rdata_q <= flag_q[addr_i[1:0]*16 +: 16];
                    end else if (addr_i[7:2] == `IPC_OFF_EN0 >> 2) begin
                        rdata_q <= en_q[addr_i[1:0]*16 +: 16];
                    end else if (addr_i[7:4] == `IPC_OFF_PRI0 >> 4) begin
                        for (int s = 0; s < 4; s++) begin
                            rdata_q[s*4 +: 3] <= pri_q[(addr_i[3:0]*4+s)*3 +: 3];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_o                 = rdata_q;
    assign irq_o                   = trap_hit | arb_hit;
    assign pending_vector_number_o = vec_q;
    assign pending_level_field_o   = ilr_q;
    assign cpu_priority_level_o    = {lvl_hi_q, lvl_lo_q};
    assign variable_latency_o      = var_q;
endmodule : ipc_ctrl

/* inc/ipc_params.svh */
// register offsets, field positions, reset values and sizes of the interrupt priority control
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

`define IPC_NSRC          64
`define IPC_NFLAGW        4
`define IPC_NPRIW         16
`define IPC_VEC_BASE      8'h08

`define IPC_ADDR_W        8
`define IPC_OFF_STATUS    8'h00
`define IPC_OFF_CORE      8'h01
`define IPC_OFF_TRAP1     8'h02
`define IPC_OFF_GLOB2     8'h03
`define IPC_OFF_SOFT3     8'h04
`define IPC_OFF_HARD4     8'h05
`define IPC_OFF_VECLATCH  8'h06
`define IPC_OFF_FLAG0     8'h10
`define IPC_OFF_EN0       8'h20
`define IPC_OFF_PRI0      8'h30

`define IPC_SR_LVL_LO     5
`define IPC_CC_VAR        15
`define IPC_CC_LVL_HI     3
`define IPC_T1_NEST       15
`define IPC_T1_OVA_TE     10
`define IPC_T1_OVB_TE     9
`define IPC_T1_COV_TE     8
`define IPC_T1_ADDR       3
`define IPC_T1_STK        2
`define IPC_T1_OSC        1
`define IPC_G2_GIE        15
`define IPC_S3_DAE        5
`define IPC_S3_LOOP       4
`define IPC_H4_SOFT_HARD_TRAP_FLAG       0

`define IPC_T1_WMASK      16'hfffe
`define IPC_G2_WMASK      16'he007
`define IPC_S3_WMASK      16'h0030
`define IPC_H4_WMASK      16'h0001
`define IPC_PRI_WMASK     16'h7777
`define IPC_G2_RESET      16'h8000

`endif

/* inc/ipc_pkg.sv */
// types shared by the interrupt priority control files
package ipc_pkg;
    typedef logic [15:0] ipc_word_t;
    typedef logic [2:0]  ipc_pri_t;
    typedef logic [3:0]  ipc_lvl_t;
    typedef logic [7:0]  ipc_vec_t;
    typedef enum logic [2:0] {
        IPC_TRAP_ADDR  = 3'h1,
        IPC_TRAP_HARD  = 3'h2,
        IPC_TRAP_STACK = 3'h3,
        IPC_TRAP_MATH  = 3'h4,
        IPC_TRAP_DMA   = 3'h5,
        IPC_TRAP_SOFT  = 3'h6
    } ipc_trap_t;
endpackage : ipc_pkg

/* core/ipc_edge_det.sv */
// external line edge detector with selectable polarity
module ipc_edge_det (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // line and polarity
    input  wire logic line_i,
    input  wire logic falling_i,
    // event
    output logic      edge_o
);
    logic line_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_q <= 1'b0;
        end else begin
            line_q <= line_i;
        end
    end

    // one selects falling, zero rising
    assign edge_o = falling_i ? (line_q & ~line_i) : (~line_q & line_i);
endmodule : ipc_edge_det

/* core/ipc_arbiter.sv */
// picks the highest-priority eligible source, lowest index on ties
module ipc_arbiter (
    // candidates
    input  wire logic [63:0]            elig_i,
    input  wire logic [191:0]           pri_i,
    // winner
    output logic                        hit_o,
    output logic [5:0]                  idx_o,
    output ipc_pkg::ipc_pri_t           pri_o
);
    import ipc_pkg::*;

    always_comb begin
        hit_o = 1'b0;
        idx_o = 6'h00;
        pri_o = 3'h0;
        // descending scan so the lowest index wins a tie
        for (int i = 63; i >= 0; i--) begin
            if (elig_i[i] && (!hit_o || pri_i[i*3 +: 3] >= pri_o)) begin
                hit_o = 1'b1;
                idx_o = 6'(i);
                pri_o = pri_i[i*3 +: 3];
            end
        end
    end
endmodule : ipc_arbiter

/* tb/ipc_ctrl_chk.sv */
// port-level assertions for the interrupt priority control
module ipc_ctrl_chk (
    // clock and reset
    input wire logic               clk_i,
    input wire logic               nrst_i,
    // register port
    input wire logic [7:0]         addr_i,
    input wire ipc_pkg::ipc_word_t wdata_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire ipc_pkg::ipc_word_t rdata_o,
    // cpu side
    input wire logic               cpu_level_load_i,
    input wire ipc_pkg::ipc_lvl_t  cpu_level_new_i,
    input wire logic               irq_o,
    input wire ipc_pkg::ipc_vec_t  pending_vector_number_o,
    input wire ipc_pkg::ipc_lvl_t  pending_level_field_o,
    input wire ipc_pkg::ipc_lvl_t  cpu_priority_level_o,
    input wire logic               variable_latency_o
);
    import ipc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence rd_at(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence
    sequence wr_at(logic [7:0] a);
        wr_i && addr_i == a;
    endsequence
    ////////////////////////////////////////
    unmapped_zero_a: assert property (rd_at(8'h07) |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    soft_bits_a: assert property (rd_at(8'h04) |=> (rdata_o & 16'hffcf) == 16'h0000)
        else $error("soft trap word unused bits set");
    hard_bits_a: assert property (rd_at(8'h05) |=> rdata_o[15:1] == 15'h0000)
        else $error("hard trap word unused bits set");
    latch_read_a: assert property (rd_at(8'h06) |=> rdata_o ==
        {4'h0, $past(pending_level_field_o), $past(pending_vector_number_o)})
        else $error("pending latch read mismatch");
    high_bit_ro_a: assert property (!cpu_level_load_i |=> $stable(cpu_priority_level_o[3]))
        else $error("level high bit moved without core load");
    level_load_a: assert property (cpu_level_load_i |=>
        cpu_priority_level_o == $past(cpu_level_new_i))
        else $error("cpu level not loaded");
    latency_sel_a: assert property (wr_at(8'h01) |=>
        variable_latency_o == $past(wdata_i[15]))
        else $error("latency select not written");
    win_above_a: assert property (irq_o |=>
        pending_level_field_o >= $past(cpu_priority_level_o))
        else $error("pending level below cpu level");
    trap_level_a: assert property (irq_o |=>
        (pending_vector_number_o < 8'h08) == (pending_level_field_o == 4'hf))
        else $error("trap and level disagree");
    vec_legal_a: assert property (irq_o |=>
        pending_vector_number_o != 8'h00 && pending_vector_number_o != 8'h07)
        else $error("illegal vector latched");
    high_block_a: assert property (irq_o && cpu_priority_level_o[3] |=>
        pending_vector_number_o < 8'h08)
        else $error("user source above level seven");
endmodule : ipc_ctrl_chk

bind ipc_ctrl ipc_ctrl_chk u_chk (
    .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cpu_level_load_i(cpu_level_load_i),
    .cpu_level_new_i(cpu_level_new_i), .irq_o(irq_o),
    .pending_vector_number_o(pending_vector_number_o),
    .pending_level_field_o(pending_level_field_o),
    .cpu_priority_level_o(cpu_priority_level_o), .variable_latency_o(variable_latency_o)
);

/* tb/ipc_src_model.sv */
// peripheral request sources: one request pulse per commanded event
module ipc_src_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // command
    input  wire logic        fire_i,
    input  wire logic [5:0]  sel_i,
    // request lines
    output logic      [63:0] src_req_o
);
    // one cycle only, so a held line cannot hide a software clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            src_req_o <= 64'h0;
        end else begin
            src_req_o <= fire_i ? (64'h1 << sel_i) : 64'h0;
        end
    end
endmodule : ipc_src_model

/* tb/ipc_ctrl_tb.sv */
// self-checking bench for the interrupt priority control
module ipc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ipc_pkg::*;
    logic       clk_i, nrst_i, wr_i, rd_i, fire, lvl_ld, hold, irq, var_lat;
    logic [7:0] addr_i;
    ipc_word_t  wdata_i, rdata_o, got;
    ipc_word_t  pw [16];
    logic [63:0] src_req;
    logic [2:0] ext;
    logic [13:0] trp;
    logic [5:0] sel;
    ipc_lvl_t   lvl_new, lvl_o, pend_lvl;
    ipc_vec_t   pend_vec;
    int         err_total, checked, n1, n2, p1, p2;
    logic [7:0] treg [14] = '{2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 4, 4, 5};
    int         tbit [14] = '{3, 2, 1, 4, 5, 7, 6, 14, 13, 12, 11, 5, 4, 0};
    logic [7:0] tvec [14] = '{1, 3, 0, 4, 5, 0, 0, 0, 0, 0, 0, 0, 0, 2};
    int         sidx [3] = '{0, 20, 29};
    ipc_ctrl DUT (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .src_req_i(src_req), .ext_line_i(ext),
        .address_fault_i(trp[0]), .stack_fault_i(trp[1]), .oscillator_fault_i(trp[2]),
        .math_fault_i(trp[3]), .dma_controller_trap_i(trp[4]), .shift_accum_fault_i(trp[5]),
        .divide_zero_i(trp[6]), .accum_a_overflow_i(trp[7]), .accum_b_overflow_i(trp[8]),
        .accum_a_catastrophic_i(trp[9]), .accum_b_catastrophic_i(trp[10]),
        .dma_address_fault_i(trp[11]), .loop_stack_overflow_i(trp[12]),
        .software_trap_request_i(trp[13]), .priority_hold_active_i(hold),
        .cpu_level_load_i(lvl_ld), .cpu_level_new_i(lvl_new), .irq_o(irq),
        .pending_vector_number_o(pend_vec), .pending_level_field_o(pend_lvl),
        .cpu_priority_level_o(lvl_o), .variable_latency_o(var_lat));
    ipc_src_model u_src (.clk_i(clk_i), .nrst_i(nrst_i), .fire_i(fire), .sel_i(sel),
                         .src_req_o(src_req));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    ////////////////////////////////////////
    task automatic wrap_up();
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input ipc_word_t g, input ipc_word_t e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input ipc_word_t d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        got = rdata_o;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input ipc_word_t e);
        rd(a);
        chk(got, e);
    endtask : rdchk
    task automatic ld(input ipc_lvl_t v);
        @(posedge clk_i);
        lvl_ld  <= 1'b1;
        lvl_new <= v;
        @(posedge clk_i);
        lvl_ld <= 1'b0;
    endtask : ld
    task automatic fire_src(input logic [5:0] n);
        @(posedge clk_i);
        fire <= 1'b1;
        sel  <= n;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask : fire_src
    task automatic pulse(input int i);
        @(posedge clk_i);
        trp[i] <= 1'b1;
        @(posedge clk_i);
        trp <= '0;
    endtask : pulse
    task automatic irqchk(input logic e);
        repeat (2) @(posedge clk_i);
        #1;
        chk({15'h0, irq}, {15'h0, e});
    endtask : irqchk
    task automatic wait_irq();
        for (int n = 0; n < 16 && irq !== 1'b1; n++) @(posedge clk_i);
        chk({15'h0, irq}, 16'h0001);
        if (irq !== 1'b1) wrap_up();
    endtask : wait_irq
    // lines hold steady while the polarity is written, so each polarity change is safe before the edge
    task automatic edge_try(input int j, input logic pol, input logic lv, input logic e);
        ipc_word_t m;
        m = 16'(1 << (sidx[j] % 16));
        wr(8'h03, 16'h8000 | 16'({pol, 2'b00} >> (2 - j)));
        wr(8'(16 + sidx[j] / 16), 16'h0000);
        @(posedge clk_i);
        ext[j] <= lv;
        repeat (4) @(posedge clk_i);
        rd(8'(16 + sidx[j] / 16));
        chk(got & m, e ? m : 16'h0000);
    endtask : edge_try
    function automatic int winner(int a, int pa, int b, int pb);
        return (pa > pb || (pa == pb && a < b)) ? a : b;
    endfunction : winner
    ////////////////////////////////////////
    initial begin
        {nrst_i, wr_i, rd_i, fire, lvl_ld, hold} = '0;
        {addr_i, wdata_i, ext, trp, sel, lvl_new} = '0;
        err_total = 0;
        checked = 0;
        void'($urandom(32'h7339));
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 7; i++) rdchk(8'(i), (i == 3) ? 16'h8000 : 16'h0000);
        wr(8'h07, 16'hffff);
        rdchk(8'h07, 16'h0000);
        wr(8'h04, 16'hffff);
        rdchk(8'h04, 16'h0030);
        wr(8'h05, 16'hffff);
        rdchk(8'h05, 16'h0001);
        hold <= 1'b1;
        wr(8'h03, 16'hffff);
        rdchk(8'h03, 16'he007);
        wr(8'h02, 16'hffff);
        rdchk(8'h02, 16'hfffe);
        wr(8'h00, 16'h00e0);
        rdchk(8'h00, 16'h0000);
        wr(8'h02, 16'h0000);
        wr(8'h00, 16'h00e0);
        rdchk(8'h00, 16'h00e0);
        wr(8'h01, 16'hffff);
        rdchk(8'h01, 16'h8000);
        ld(4'h8);
        rdchk(8'h01, 16'h8008);
        rdchk(8'h00, 16'h0000);
        ld(4'h0);
        hold <= 1'b0;
        for (int i = 1; i < 6; i++) wr(8'(i), (i == 3) ? 16'h8000 : 16'h0000);
        for (int w = 0; w < 4; w++) wr(8'(32 + w), 16'hffff);
        for (int k = 0; k < 12; k++) begin
            n1 = $urandom_range(63);
            n2 = (n1 + 1 + $urandom_range(61)) % 64;
            p1 = $urandom_range(7, 1);
            p2 = (k < 4) ? p1 : $urandom_range(7, 1);
            pw = '{default: 16'h0};
            pw[n1 / 4][4 * (n1 % 4) +: 3] = 3'(p1);
            pw[n2 / 4][4 * (n2 % 4) +: 3] = 3'(p2);
            wr(8'(48 + n1 / 4), pw[n1 / 4]);
            wr(8'(48 + n2 / 4), pw[n2 / 4]);
            fire_src(6'(n1));
            fire_src(6'(n2));
            wait_irq();
            rdchk(8'(16 + n1 / 16), 16'(1 << (n1 % 16)) |
                  ((n1 / 16 == n2 / 16) ? 16'(1 << (n2 % 16)) : 16'h0000));
            rdchk(8'h06, {4'h0, 4'(p1 > p2 ? p1 : p2), 8'(winner(n1, p1, n2, p2) + 8)});
            wr(8'(16 + n1 / 16), 16'h0000);
            wr(8'(16 + n2 / 16), 16'h0000);
        end
        wr(8'h3a, 16'h0003);
        for (int w = 0; w < 4; w++) wr(8'(32 + w), 16'h0000);
        fire_src(6'd40);
        irqchk(1'b0);
        wr(8'h22, 16'h0100);
        irqchk(1'b1);
        wr(8'h00, 16'h0060);
        irqchk(1'b0);
        wr(8'h00, 16'h0040);
        irqchk(1'b1);
        ld(4'h8);
        irqchk(1'b0);
        ld(4'h0);
        wr(8'h03, 16'h0000);
        irqchk(1'b0);
        pulse(0);
        irqchk(1'b1);
        wr(8'h12, 16'h0000);
        wr(8'h03, 16'ha000);
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            rd(treg[i]);
            chk(got & 16'(1 << tbit[i]), 16'(1 << tbit[i]));
            if (tvec[i] != 8'h00) rdchk(8'h06, {8'h0f, tvec[i]});
            wr(treg[i], 16'h0000);
        end
        for (int j = 0; j < 3; j++) begin
            edge_try(j, 1'b0, 1'b1, 1'b1);
            edge_try(j, 1'b1, 1'b0, 1'b1);
            edge_try(j, 1'b1, 1'b1, 1'b0);
        end
        wrap_up();
    end
endmodule : ipc_ctrl_tb
